// ---- hw/phase_power_state_defines.vh ----
// constants for the phase and power-state control block
`ifndef PHASE_POWER_STATE_DEFINES_VH
`define PHASE_POWER_STATE_DEFINES_VH
// wishbone register byte offsets
`define REG_CONTROL 4'h0
`define REG_CORE_STATUS 4'h4
`define REG_AUX_STATUS 4'h8
`define REG_STRAP_A 4'hC
// control register field positions
`define CTRL_CORE_SEL_BIT 0
`define CTRL_AUX_SEL_BIT 1
`define CTRL_PS0_N_BIT 2
`define CTRL_PS1_N_BIT 3
`define CTRL_CORE_TRANS_BIT 4
`define CTRL_AUX_TRANS_BIT 5
// control reset value: both selectors clear, both power-save bits high
`define CTRL_RESET 8'h0C
// phase configuration
`define CORE_MAX_PHASES 3'h4
`define AUX_MAX_PHASES 2'h2
// strap field widths
`define STRAP_WIDTH 8
`define STRAP_B_WIDTH 10
`endif

// ---- hw/phase_count_latch.v ----
// core rail phase count detection and latch
`timescale 1ns/10ps
module phase_count_latch (
    input wire clk_i,
    input wire rst_i,
    input wire enable_rise_i,
    input wire por_done_i,
    input wire phase2_sense_neg_i,
    input wire phase3_sense_neg_i,
    input wire phase4_sense_neg_i,
    output reg [2:0] phase_count_o,
    output reg locked_o
);
`include "phase_power_state_defines.vh"
    // sense inputs are comparator outputs: high means above supply minus 0.5 V
    always @(posedge clk_i) begin
        if (rst_i) begin
            phase_count_o <= `CORE_MAX_PHASES;
            locked_o <= 1'b0;
        end else if (!locked_o) begin
            if (enable_rise_i) begin
                // lowest strapped phase wins: phase 2 tie forces single phase
                if (phase2_sense_neg_i)
                    phase_count_o <= 3'h1;
                else if (phase3_sense_neg_i)
                    phase_count_o <= 3'h2;
                else if (phase4_sense_neg_i)
                    phase_count_o <= 3'h3;
                else
                    phase_count_o <= `CORE_MAX_PHASES;
            end
            if (por_done_i)
                locked_o <= 1'b1;
        end
    end
endmodule

// ---- hw/strap_capture.v ----
// one-shot capture of the configuration straps
`timescale 1ns/10ps
module strap_capture (
    input wire clk_i,
    input wire rst_i,
    input wire enable_rise_i,
    input wire adc_valid_i,
    input wire [7:0] strap_a_code_i,
    input wire [7:0] strap_b_code_i,
    input wire [7:0] gain_strap_code_i,
    output reg [7:0] strap_a_o,
    output reg [7:0] strap_b_o,
    output reg [7:0] gain_strap_o,
    output reg straps_done_o,
    output reg gain_done_o
);
    // straps a and b decode once; the bias current then corrupts the pin voltage
    always @(posedge clk_i) begin
        if (rst_i) begin
            strap_a_o <= 8'h00;
            strap_b_o <= 8'h00;
            straps_done_o <= 1'b0;
        end else if (adc_valid_i && !straps_done_o) begin
            strap_a_o <= strap_a_code_i;
            strap_b_o <= strap_b_code_i;
            straps_done_o <= 1'b1;
        end
    end
    // gain strap sampled at enable rise, then the pin becomes the reference output
    always @(posedge clk_i) begin
        if (rst_i) begin
            gain_strap_o <= 8'h00;
            gain_done_o <= 1'b0;
        end else if (enable_rise_i && !gain_done_o) begin
            gain_strap_o <= gain_strap_code_i;
            gain_done_o <= 1'b1;
        end
    end
endmodule

// ---- hw/phase_power_state_control.v ----
// power-state decode, phase control and register slave for the two-rail regulator
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/10ps
module phase_power_state_control #(
    parameter AUX_PHASES = 2
) (
    input wire clk_i,
    input wire rst_i,
    input wire enable_i,
    input wire por_done_i,
    input wire phase2_sense_neg_i,
    input wire phase3_sense_neg_i,
    input wire phase4_sense_neg_i,
    input wire adc_valid_i,
    input wire [7:0] config_strap_a_i,
    input wire [7:0] config_strap_b_i,
    input wire [7:0] ref_out_gain_strap_i,
    input wire cmd_valid_i,
    input wire cmd_core_sel_i,
    input wire cmd_aux_sel_i,
    input wire power_save_bit0_n_i,
    input wire power_save_bit1_n_i,
    input wire core_transition_i,
    input wire aux_transition_i,
    input wire [31:0] adr_i,
    input wire [31:0] dat_i,
    input wire [3:0] sel_i,
    input wire we_i,
    input wire cyc_i,
    input wire stb_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    output reg [2:0] core_phases_o,
    output reg core_diode_emulation_o,
    output reg [1:0] aux_phases_o,
    output reg aux_diode_emulation_o,
    output wire strap_bias_en_o,
    output wire ref_out_en_o,
    output wire [1:0] current_limit_threshold_o,
    output wire [1:0] dynamic_vid_comp_o,
    output wire [1:0] core_ramp_amplitude_o,
    output wire [1:0] aux_ramp_amplitude_o,
    output wire [1:0] current_limit_trigger_delay_o,
    output wire ext_offset_en_o,
    output wire [1:0] core_quick_response_thresh_o,
    output wire [1:0] aux_quick_response_thresh_o,
    output wire [7:0] current_gain_ratio_o
);
`include "phase_power_state_defines.vh"

    // power-save mode codes, one-hot
    localparam MODE_FULL = 3'b001;
    localparam MODE_SHED = 3'b010;
    localparam MODE_DIODE = 3'b100;

    reg enable_q;
    reg [7:0] control;
    reg [2:0] core_mode;
    reg [2:0] aux_mode;
    reg [2:0] next_core_phases;
    reg next_core_diode;
    reg [1:0] next_aux_phases;
    reg next_aux_diode;
    reg [31:0] next_dat;
    wire enable_rise;
    wire [2:0] full_core;
    wire phase_locked;
    wire [7:0] strap_a;
    wire [7:0] strap_b;
    wire straps_done;
    wire gain_done;
    wire bus_req;
    wire adr_hit;
    wire sw_cmd;
    wire cmd_take;
    wire take_core_sel;
    wire take_aux_sel;
    wire take_ps0_n;
    wire take_ps1_n;
    wire [1:0] full_aux;

    // map power-save bit pair to a mode code; bit0 high means full power
    function [2:0] decode_mode;
        input ps0_n;
        input ps1_n;
        begin
            if (ps0_n)
                decode_mode = MODE_FULL;
            else if (ps1_n)
                decode_mode = MODE_SHED;
            else
                decode_mode = MODE_DIODE;
        end
    endfunction

    assign full_aux = (AUX_PHASES >= 2) ? `AUX_MAX_PHASES : 2'h1;
    assign enable_rise = enable_i & ~enable_q;

    // enable edge detector; enable is taken as synchronous
    always @(posedge clk_i) begin
        if (rst_i)
            enable_q <= 1'b0;
        else
            enable_q <= enable_i;
    end

    phase_count_latch u_phase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_rise_i(enable_rise),
        .por_done_i(por_done_i),
        .phase2_sense_neg_i(phase2_sense_neg_i),
        .phase3_sense_neg_i(phase3_sense_neg_i),
        .phase4_sense_neg_i(phase4_sense_neg_i),
        .phase_count_o(full_core),
        .locked_o(phase_locked)
    );

    strap_capture u_strap (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_rise_i(enable_rise),
        .adc_valid_i(adc_valid_i),
        .strap_a_code_i(config_strap_a_i),
        .strap_b_code_i(config_strap_b_i),
        .gain_strap_code_i(ref_out_gain_strap_i),
        .strap_a_o(strap_a),
        .strap_b_o(strap_b),
        .gain_strap_o(current_gain_ratio_o),
        .straps_done_o(straps_done),
        .gain_done_o(gain_done)
    );

    assign strap_bias_en_o = straps_done;
    assign ref_out_en_o = gain_done;

    // strap a: threshold [7:6], comp bit1 [5], core ramp [4:3], aux ramp [2:1]
    assign current_limit_threshold_o = strap_a[7:6];
    assign core_ramp_amplitude_o = strap_a[4:3];
    assign aux_ramp_amplitude_o = strap_a[2:1];
    // strap b: delay [7:6], comp bit0 [5], offset enable [4], thresholds [3:0]
    assign current_limit_trigger_delay_o = strap_b[7:6];
    assign dynamic_vid_comp_o = {strap_a[5], strap_b[5]};
    assign ext_offset_en_o = strap_b[4];
    assign core_quick_response_thresh_o = strap_b[3:2];
    assign aux_quick_response_thresh_o = strap_b[1:0];

    // wishbone classic slave, one registered ack per request, one wait state
    assign bus_req = cyc_i & stb_i & ~ack_o;
    // full decode so that higher addresses do not alias onto the four registers
    assign adr_hit = (adr_i[31:4] == 28'h0000000);
    // any write to control with byte lane 0 enabled issues a software command; the select bits pick which rails move
    assign sw_cmd = bus_req & we_i & sel_i[0] & adr_hit & (adr_i[3:0] == `REG_CONTROL);
    // link command has priority; software command reuses the same path
    assign cmd_take = cmd_valid_i | sw_cmd;
    assign take_core_sel = cmd_valid_i ? cmd_core_sel_i : dat_i[`CTRL_CORE_SEL_BIT];
    assign take_aux_sel = cmd_valid_i ? cmd_aux_sel_i : dat_i[`CTRL_AUX_SEL_BIT];
    assign take_ps0_n = cmd_valid_i ? power_save_bit0_n_i : dat_i[`CTRL_PS0_N_BIT];
    assign take_ps1_n = cmd_valid_i ? power_save_bit1_n_i : dat_i[`CTRL_PS1_N_BIT];

    // commanded mode per rail; only a selected rail moves
    always @(posedge clk_i) begin
        if (rst_i) begin
            core_mode <= MODE_FULL;
            aux_mode <= MODE_FULL;
        end else if (cmd_take) begin
            if (take_core_sel)
                core_mode <= decode_mode(take_ps0_n, take_ps1_n);
            if (take_aux_sel)
                aux_mode <= decode_mode(take_ps0_n, take_ps1_n);
        end
    end

    // control register: transition override bits and last software command image
    always @(posedge clk_i) begin
        if (rst_i)
            control <= `CTRL_RESET;
        else if (sw_cmd)
            control <= dat_i[7:0];
    end

    // phase and conduction decode, with transition override
    always @* begin
        case (core_mode)
            MODE_FULL: begin
                next_core_phases = full_core;
                next_core_diode = 1'b0;
            end
            MODE_SHED: begin
                next_core_phases = (full_core > 3'h1) ? full_core - 3'h1 : 3'h1;
                next_core_diode = 1'b0;
            end
            MODE_DIODE: begin
                next_core_phases = 3'h1;
                next_core_diode = 1'b1;
            end
            default: begin
                next_core_phases = full_core;
                next_core_diode = 1'b0;
            end
        endcase
        case (aux_mode)
            MODE_FULL: begin
                next_aux_phases = full_aux;
                next_aux_diode = 1'b0;
            end
            MODE_SHED: begin
                next_aux_phases = 2'h1;
                next_aux_diode = 1'b0;
            end
            MODE_DIODE: begin
                next_aux_phases = 2'h1;
                next_aux_diode = 1'b1;
            end
            default: begin
                next_aux_phases = full_aux;
                next_aux_diode = 1'b0;
            end
        endcase
        // during a target change the rail runs full and continuous
        if (core_transition_i | control[`CTRL_CORE_TRANS_BIT]) begin
            next_core_phases = full_core;
            next_core_diode = 1'b0;
        end
        if (aux_transition_i | control[`CTRL_AUX_TRANS_BIT]) begin
            next_aux_phases = full_aux;
            next_aux_diode = 1'b0;
        end
    end

    // registered rail outputs; one cycle behind the mode state
    always @(posedge clk_i) begin
        if (rst_i) begin
            core_phases_o <= `CORE_MAX_PHASES;
            core_diode_emulation_o <= 1'b0;
            aux_phases_o <= full_aux;
            aux_diode_emulation_o <= 1'b0;
        end else begin
            core_phases_o <= next_core_phases;
            core_diode_emulation_o <= next_core_diode;
            aux_phases_o <= next_aux_phases;
            aux_diode_emulation_o <= next_aux_diode;
        end
    end

    // read mux; unmapped addresses read zero and still ack
    always @* begin
        next_dat = 32'h00000000;
        if (adr_hit) begin
            case (adr_i[3:0])
                `REG_CONTROL: next_dat = {24'h000000, control};
                `REG_CORE_STATUS: next_dat = {22'h000000, phase_locked, core_mode, core_diode_emulation_o,
                                              full_core, 2'h0};
                `REG_AUX_STATUS: next_dat = {24'h000000, aux_mode, aux_diode_emulation_o, full_aux, aux_phases_o};
                `REG_STRAP_A: next_dat = {6'h00, gain_done, straps_done, current_gain_ratio_o, strap_b, strap_a};
                default: next_dat = 32'h00000000;
            endcase
        end
    end

    // ack one cycle after request, dropped the cycle after
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= bus_req;
            if (bus_req && !we_i)
                dat_o <= next_dat;
        end
    end

endmodule

// ---- verif/phase_power_state_props.sv ----
// concurrent checks on the power-state control ports
`timescale 1ns/10ps
module phase_power_state_props #(
    parameter AUX_PHASES = 2
) (
    input wire clk_i,
    input wire rst_i,
    input wire cmd_valid_i,
    input wire cmd_core_sel_i,
    input wire cmd_aux_sel_i,
    input wire power_save_bit0_n_i,
    input wire power_save_bit1_n_i,
    input wire core_transition_i,
    input wire aux_transition_i,
    input wire cyc_i,
    input wire [2:0] core_phases_o,
    input wire core_diode_emulation_o,
    input wire [1:0] aux_phases_o,
    input wire aux_diode_emulation_o,
    input wire strap_bias_en_o,
    input wire ref_out_en_o,
    input wire [1:0] current_limit_threshold_o,
    input wire [7:0] current_gain_ratio_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // selected command, with no transition forcing full phases over the two decode cycles
    sequence s_core(b0, b1);
        cmd_valid_i && cmd_core_sel_i && power_save_bit0_n_i == b0 && (b0 || power_save_bit1_n_i == b1)
            && !core_transition_i ##1 !core_transition_i;
    endsequence
    sequence s_aux(b0, b1);
        cmd_valid_i && cmd_aux_sel_i && power_save_bit0_n_i == b0 && (b0 || power_save_bit1_n_i == b1)
            && !aux_transition_i ##1 !aux_transition_i;
    endsequence
    property p_reset_state;
        $fell(rst_i) |-> core_phases_o == 3'h4 && !core_diode_emulation_o && aux_phases_o == AUX_PHASES;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("start-up state wrong");
    property p_core_dem; s_core(1'b0, 1'b0) |=> core_phases_o == 3'h1 && core_diode_emulation_o; endproperty
    a_core_dem: assert property (p_core_dem) else $error("core light load wrong");
    property p_core_full; s_core(1'b1, 1'b0) |=> core_phases_o != 3'h0 && !core_diode_emulation_o; endproperty
    a_core_full: assert property (p_core_full) else $error("core full mode wrong");
    property p_aux_ccm; s_aux(1'b0, 1'b1) |=> aux_phases_o == 2'h1 && !aux_diode_emulation_o; endproperty
    a_aux_ccm: assert property (p_aux_ccm) else $error("aux shed mode wrong");
    property p_aux_dem; s_aux(1'b0, 1'b0) |=> aux_phases_o == 2'h1 && aux_diode_emulation_o; endproperty
    a_aux_dem: assert property (p_aux_dem) else $error("aux light load wrong");
    property p_aux_full; s_aux(1'b1, 1'b0) |=> aux_phases_o == AUX_PHASES && !aux_diode_emulation_o; endproperty
    a_aux_full: assert property (p_aux_full) else $error("aux full mode wrong");
    // an unselected command must leave the core rail alone
    property p_core_unsel;
        cmd_valid_i && !cmd_core_sel_i && !cyc_i && !core_transition_i ##1 !cyc_i && !core_transition_i
            |=> $stable(core_phases_o) && $stable(core_diode_emulation_o);
    endproperty
    a_core_unsel: assert property (p_core_unsel) else $error("unselected core changed");
    property p_trans_full;
        (core_transition_i |=> !core_diode_emulation_o)
            and (aux_transition_i |=> aux_phases_o == AUX_PHASES && !aux_diode_emulation_o);
    endproperty
    a_trans_full: assert property (p_trans_full) else $error("transition not forced full");
    property p_strap_hold; strap_bias_en_o |=> strap_bias_en_o && $stable(current_limit_threshold_o); endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap decoded again");
    property p_gain_hold; ref_out_en_o |=> ref_out_en_o && $stable(current_gain_ratio_o); endproperty
    a_gain_hold: assert property (p_gain_hold) else $error("gain strap sampled again");
endmodule
bind phase_power_state_control phase_power_state_props #(.AUX_PHASES(AUX_PHASES)) i_phase_power_state_props (.*);

// ---- verif/ps_cmd_master.sv ----
// processor-side model that hands decoded power-state commands to the block
`timescale 1ns/10ps
module ps_cmd_master (
    input wire logic clk_i,
    output logic valid_o,
    output logic core_sel_o,
    output logic aux_sel_o,
    output logic ps0_n_o,
    output logic ps1_n_o
);
    // idle: no command pending
    initial begin
        valid_o = 1'b0;
        {core_sel_o, aux_sel_o, ps0_n_o, ps1_n_o} = 4'hF;
    end
    // one pulse after some idle cycles; qualifiers are inverted after it so stale values never pass as valid
    task automatic issue(input logic cs, input logic as, input logic b0, input logic b1, input int idle);
        repeat (idle) @(posedge clk_i);
        @(posedge clk_i);
        valid_o <= 1'b1;
        {core_sel_o, aux_sel_o} <= {cs, as};
        {ps0_n_o, ps1_n_o} <= {b0, b1};
        @(posedge clk_i);
        valid_o <= 1'b0;
        {core_sel_o, aux_sel_o, ps0_n_o, ps1_n_o} <= ~{cs, as, b0, b1};
    endtask
endmodule

// ---- verif/testbench.sv ----
// self-checking testbench for the phase and power-state control block
`timescale 1ns/10ps
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic enable_i = 1'b0, por_done_i = 1'b0, adc_valid_i = 1'b0;
    logic phase2_sense_neg_i = 1'b0, phase3_sense_neg_i = 1'b0, phase4_sense_neg_i = 1'b0;
    logic [7:0] config_strap_a_i = 8'h00, config_strap_b_i = 8'h00, ref_out_gain_strap_i = 8'h5A;
    logic core_transition_i = 1'b0, aux_transition_i = 1'b0;
    logic [31:0] adr_i = 32'h0, dat_i = 32'h0, rd;
    logic [3:0] sel_i = 4'h0;
    logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
    wire cmd_valid_i, cmd_core_sel_i, cmd_aux_sel_i, power_save_bit0_n_i, power_save_bit1_n_i;
    wire [31:0] dat_o;
    wire ack_o, core_diode_emulation_o, aux_diode_emulation_o, strap_bias_en_o, ref_out_en_o, ext_offset_en_o;
    wire [2:0] core_phases_o;
    wire [1:0] aux_phases_o, current_limit_threshold_o, dynamic_vid_comp_o, core_ramp_amplitude_o;
    wire [1:0] aux_ramp_amplitude_o, current_limit_trigger_delay_o, core_quick_response_thresh_o;
    wire [1:0] aux_quick_response_thresh_o;
    wire [7:0] current_gain_ratio_o;
    wire [6:0] rails = {core_phases_o, core_diode_emulation_o, aux_phases_o, aux_diode_emulation_o};
    int n_errors = 0;
    int checks_done = 0;
    // {straps phase4/3/2, bit0_n, bit1_n, core phases, core diode, aux phases, aux diode}
    logic [11:0] rows [16] = '{12'h1C4, 12'h144, 12'h0B2, 12'h01B, 12'h9B4, 12'h934, 12'h8A2, 12'h81B,
                              12'h5A4, 12'h524, 12'h492, 12'h41B, 12'h394, 12'h314, 12'h292, 12'h21B};
    phase_power_state_control i_phase_power_state_control (.clk_i(clk_i), .rst_i(rst_i), .enable_i(enable_i),
        .por_done_i(por_done_i), .phase2_sense_neg_i(phase2_sense_neg_i), .phase3_sense_neg_i(phase3_sense_neg_i),
        .phase4_sense_neg_i(phase4_sense_neg_i), .adc_valid_i(adc_valid_i), .config_strap_a_i(config_strap_a_i),
        .config_strap_b_i(config_strap_b_i), .ref_out_gain_strap_i(ref_out_gain_strap_i),
        .cmd_valid_i(cmd_valid_i), .cmd_core_sel_i(cmd_core_sel_i), .cmd_aux_sel_i(cmd_aux_sel_i),
        .power_save_bit0_n_i(power_save_bit0_n_i), .power_save_bit1_n_i(power_save_bit1_n_i),
        .core_transition_i(core_transition_i), .aux_transition_i(aux_transition_i), .adr_i(adr_i), .dat_i(dat_i),
        .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
        .core_phases_o(core_phases_o), .core_diode_emulation_o(core_diode_emulation_o),
        .aux_phases_o(aux_phases_o), .aux_diode_emulation_o(aux_diode_emulation_o),
        .strap_bias_en_o(strap_bias_en_o), .ref_out_en_o(ref_out_en_o),
        .current_limit_threshold_o(current_limit_threshold_o), .dynamic_vid_comp_o(dynamic_vid_comp_o),
        .core_ramp_amplitude_o(core_ramp_amplitude_o), .aux_ramp_amplitude_o(aux_ramp_amplitude_o),
        .current_limit_trigger_delay_o(current_limit_trigger_delay_o), .ext_offset_en_o(ext_offset_en_o),
        .core_quick_response_thresh_o(core_quick_response_thresh_o),
        .aux_quick_response_thresh_o(aux_quick_response_thresh_o), .current_gain_ratio_o(current_gain_ratio_o));
    ps_cmd_master i_ps_cmd_master (.clk_i(clk_i), .valid_o(cmd_valid_i), .core_sel_o(cmd_core_sel_i),
        .aux_sel_o(cmd_aux_sel_i), .ps0_n_o(power_save_bit0_n_i), .ps1_n_o(power_save_bit1_n_i));
    always #12.5 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // classic single cycle; the wait is bounded so a dead slave cannot hang the run
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hF};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        chk(ack_o, 1'b1);
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask
    // reset, then enable rise with the given phase straps, then power-on reset done
    task automatic start(input logic [2:0] st);
        @(posedge clk_i);
        {rst_i, enable_i, por_done_i, ref_out_gain_strap_i} <= {3'b100, 8'h5A};
        {phase4_sense_neg_i, phase3_sense_neg_i, phase2_sense_neg_i} <= st;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        enable_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        por_done_i <= 1'b1;
        @(posedge clk_i);
    endtask
    // mode register then output register: two edges after the command
    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #(25 * 3000);
        n_errors++;
        conclude();
    end
    initial begin
        start(3'h0);
        #1;
        chk(rails, 7'h44);
        foreach (rows[i]) begin
            start(rows[i][11:9]);
            i_ps_cmd_master.issue(1'b1, 1'b1, rows[i][8], rows[i][7], i % 3);
            settle();
            chk(rails, rows[i][6:0]);
        end
        start(3'h0);
        i_ps_cmd_master.issue(1'b1, 1'b0, 1'b0, 1'b0, 0);
        settle();
        chk(rails, 7'h1C);
        i_ps_cmd_master.issue(1'b0, 1'b1, 1'b0, 1'b0, 1);
        settle();
        chk(rails, 7'h1B);
        @(posedge clk_i);
        {core_transition_i, aux_transition_i} <= 2'b11;
        settle();
        chk(rails, 7'h44);
        @(posedge clk_i);
        {core_transition_i, aux_transition_i} <= 2'b00;
        settle();
        chk(rails, 7'h1B);
        // software command through the control register: both rails, shed
        wb(1'b1, 32'h0, 32'h0B, rd);
        settle();
        chk(rails, 7'h32);
        wb(1'b0, 32'h4, 32'h0, rd);
        chk(rd, 32'h290);
        wb(1'b0, 32'h10, 32'h0, rd);
        chk(rd, 32'h0);
        @(posedge clk_i);
        {config_strap_a_i, config_strap_b_i, adc_valid_i} <= {16'hB56C, 1'b1};
        @(posedge clk_i);
        {config_strap_a_i, config_strap_b_i, adc_valid_i} <= {16'h4A93, 1'b0};
        repeat (2) @(posedge clk_i);
        adc_valid_i <= 1'b1;
        @(posedge clk_i);
        adc_valid_i <= 1'b0;
        settle();
        chk({strap_bias_en_o, current_limit_threshold_o, dynamic_vid_comp_o, core_ramp_amplitude_o,
            aux_ramp_amplitude_o, current_limit_trigger_delay_o, ext_offset_en_o, core_quick_response_thresh_o,
            aux_quick_response_thresh_o}, 16'hDD2C);
        wb(1'b0, 32'hC, 32'h0, rd);
        chk(rd, 32'h035A6CB5);
        // two phase straps: the lowest one wins; a later enable rise must not re-detect
        start(3'h5);
        @(posedge clk_i);
        {enable_i, phase4_sense_neg_i, phase3_sense_neg_i, phase2_sense_neg_i} <= 4'h0;
        ref_out_gain_strap_i <= 8'hA5;
        repeat (2) @(posedge clk_i);
        enable_i <= 1'b1;
        i_ps_cmd_master.issue(1'b1, 1'b1, 1'b1, 1'b1, 2);
        settle();
        chk(rails, 7'h14);
        chk({ref_out_en_o, current_gain_ratio_o}, 9'h15A);
        conclude();
    end
endmodule
